/* File: hdl/count_link_if.sv */
// carrier between the register/control logic and the counter core
// assumes both ends sit on hclk
interface count_link_if;
    logic load;
    logic run;
    logic reload_mode;
    logic [15:0] reload_value;
    logic [15:0] count;
    logic tick;
    logic underflow;

    modport ctrl (
        output load,
        output run,
        output reload_mode,
        output reload_value,
        input count,
        input tick,
        input underflow
    );

    modport core (
        input load,
        input run,
        input reload_mode,
        input reload_value,
        output count,
        output tick,
        output underflow
    );
endinterface

/* File: hdl/down_counter_core.sv */
// 16-bit down-counter with count clock divider
// assumes load, run and reload inputs come from logic on hclk
module down_counter_core
    import timer_pkg::*;
#(
    parameter int COUNT_DIV = COUNT_DIV_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    count_link_if.core link
);

    localparam int DIV_W = (COUNT_DIV > 1) ? $clog2(COUNT_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COUNT_DIV - 1);

    if (COUNT_DIV < 1) begin : g_bad_div
        $error("COUNT_DIV must be at least 1");
    end

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [15:0] count;
    } core_s;

    core_s state;
    core_s next_state;
    logic tick;
    logic at_zero;

    // ------------------------------------------------------------
    // count clock and counting
    // ------------------------------------------------------------
    // the divider runs free, so the first event after a start comes
    // anywhere within one count clock period
    assign tick = (state.div == DIV_LAST);
    assign at_zero = (state.count == COUNT_ZERO);

    always_comb begin
        next_state = state;
        next_state.div = tick ? '0 : DIV_W'(state.div + 1'b1);
        if (link.load) begin
            next_state.count = link.reload_value;
        end else if (link.run && tick) begin
            if (at_zero) begin
                next_state.count = link.reload_mode ? link.reload_value : COUNT_ALL_ONES;
            end else begin
                next_state.count = state.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '{div: '0, count: COUNT_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign link.count = state.count;
    assign link.tick = tick;
    assign link.underflow = link.run && tick && at_zero && !link.load;

endmodule // down_counter_core

/* File: hdl/reload_down_timer_control.sv */
// one channel of a 16-bit reload down-timer behind an AHB-Lite slave
// assumes a single master, single word transfers, and that the port logic
// drives gpio_port_value on hclk
//
// Overview of operation
// - output enable selects timer waveform or port
// - one-shot: pulse while counting, level selects polarity
// - reload: start at level, invert each underflow
// - reload select 0: stop after underflow
// - reload select 1: reload and continue counting
// - interrupt enable gates underflow request
// - underflow sets flag; write 0 clears
// - locked read returns underflow flag as 1
// - count enable 0 halts counting
// - count enable 1 waits for start trigger
// - trigger honoured only with count enable
// - trigger loads reload, counting at next tick
// - enable and trigger together start at once
// - trigger reads 1 only while start pending
// - bit 7 reads 0, writes ignored
// - counter readable anytime through byte registers
// - high byte read captures low byte
// - writes to readout address update reload
// - every start loads reload before counting
// - request when flag and enable both set
// - one-shot underflow leaves counter all ones
// - reload high byte waits for low write
//
// Added by the designer: the register offsets and the AHB-Lite register port.
module reload_down_timer_control
    import timer_pkg::*;
#(
    parameter int COUNT_DIV = COUNT_DIV_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hmastlock,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic gpio_port_value,
    output logic timer_output_pin,
    output logic timer_pin_output_enable,
    output logic underflow_irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic output_enable;
        logic output_level;
        logic reload_select;
        logic irq_enable;
        logic underflow_flag;
        logic count_enable;
        run_state_e run;
        logic toggle_level;
        logic [7:0] reload_value_high;
        logic [15:0] reload;
        logic [7:0] low_capture;
        logic wr_pending;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic pin;
        logic pin_enable;
        logic irq;
    } ctl_s;

    ctl_s state;
    ctl_s next_state;

    count_link_if link ();

    down_counter_core #(
        .COUNT_DIV(COUNT_DIV)
    ) u_core (
        .hclk(hclk),
        .hresetn(hresetn),
        .link(link)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic addr_phase;
    logic word_size;
    logic ctrl_write;
    logic write_count_enable;
    logic start;
    logic [7:0] control_read;
    logic [31:0] read_mux;
    logic waveform;

    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    // only whole-word writes land; narrower writes are answered but ignored, reads of any size are served
    assign word_size = (hsize == 3'h2);
    assign ctrl_write = state.wr_pending && (state.wr_addr == OFFSET_CONTROL);

    // the new enable value counts for a trigger in the same write
    assign write_count_enable = ctrl_write ? hwdata[BIT_COUNT_ENABLE] : state.count_enable;
    assign start = ctrl_write && hwdata[BIT_TRIGGER] && write_count_enable;

    // ------------------------------------------------------------
    // counter core hookup
    // ------------------------------------------------------------
    assign link.load = start;
    assign link.run = (state.run != RUN_IDLE);
    assign link.reload_mode = state.reload_select;
    assign link.reload_value = state.reload;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        control_read = CONTROL_RESET;
        control_read[BIT_RESERVED] = 1'b0;
        control_read[BIT_OUTPUT_ENABLE] = state.output_enable;
        control_read[BIT_OUTPUT_LEVEL] = state.output_level;
        control_read[BIT_RELOAD_SELECT] = state.reload_select;
        control_read[BIT_IRQ_ENABLE] = state.irq_enable;
        // a locked read is the read half of a read-modify-write
        control_read[BIT_UNDERFLOW] = state.underflow_flag || hmastlock;
        control_read[BIT_COUNT_ENABLE] = state.count_enable;
        control_read[BIT_TRIGGER] = (state.run == RUN_ARMED);
    end

    always_comb begin
        read_mux = 32'h0000_0000;
        if (haddr == OFFSET_CONTROL) begin
            read_mux = {24'h00_0000, control_read};
        end else if (haddr == OFFSET_COUNT_HIGH) begin
            read_mux = {24'h00_0000, link.count[15:8]};
        end else if (haddr == OFFSET_COUNT_LOW) begin
            read_mux = {24'h00_0000, state.low_capture};
        end else if (haddr == OFFSET_COUNT_WORD) begin
            read_mux = {16'h0000, link.count};
        end else begin
            read_mux = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.ready = 1'b1;
        waveform = 1'b0;

        // address phase: latch writes, answer reads one edge later
        next_state.wr_pending = addr_phase && hwrite && word_size;
        next_state.wr_addr = haddr;
        if (addr_phase && !hwrite) begin
            next_state.rdata = read_mux;
            if (haddr == OFFSET_COUNT_HIGH) begin
                next_state.low_capture = link.count[7:0];
            end
        end

        // data phase: apply write data
        if (state.wr_pending) begin
            if (state.wr_addr == OFFSET_CONTROL) begin
                next_state.output_enable = hwdata[BIT_OUTPUT_ENABLE];
                next_state.output_level = hwdata[BIT_OUTPUT_LEVEL];
                next_state.reload_select = hwdata[BIT_RELOAD_SELECT];
                next_state.irq_enable = hwdata[BIT_IRQ_ENABLE];
                next_state.count_enable = hwdata[BIT_COUNT_ENABLE];
                if (!hwdata[BIT_UNDERFLOW]) begin
                    next_state.underflow_flag = 1'b0;
                end
            end else if (state.wr_addr == OFFSET_COUNT_HIGH) begin
                next_state.reload_value_high = hwdata[7:0];
            end else if (state.wr_addr == OFFSET_COUNT_LOW) begin
                next_state.reload = {state.reload_value_high, hwdata[7:0]};
            end else if (state.wr_addr == OFFSET_COUNT_WORD) begin
                next_state.reload = hwdata[15:0];
            end
        end

        // run sequencing
        case (state.run)
            RUN_IDLE: begin
                next_state.run = RUN_IDLE;
            end
            RUN_ARMED: begin
                if (link.tick) begin
                    next_state.run = RUN_COUNTING;
                end
            end
            RUN_COUNTING: begin
                next_state.run = RUN_COUNTING;
            end
            default: begin
                next_state.run = RUN_IDLE;
            end
        endcase

        if (link.underflow) begin
            // the hardware set wins over a clearing write in the same cycle
            next_state.underflow_flag = 1'b1;
            if (state.reload_select) begin
                next_state.toggle_level = !state.toggle_level;
            end else begin
                next_state.run = RUN_IDLE;
            end
        end

        if (start) begin
            next_state.run = RUN_ARMED;
            next_state.toggle_level = hwdata[BIT_OUTPUT_LEVEL];
        end
        if (!write_count_enable) begin
            next_state.run = RUN_IDLE;
        end

        // output pin and request, from the values being registered
        if (next_state.reload_select) begin
            waveform = next_state.toggle_level;
        end else begin
            waveform = (next_state.run == RUN_COUNTING) ^ next_state.output_level;
        end
        next_state.pin = next_state.output_enable ? waveform : gpio_port_value;
        next_state.pin_enable = next_state.output_enable;
        next_state.irq = next_state.underflow_flag && next_state.irq_enable;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '{
                output_enable: CONTROL_RESET[BIT_OUTPUT_ENABLE],
                output_level: CONTROL_RESET[BIT_OUTPUT_LEVEL],
                reload_select: CONTROL_RESET[BIT_RELOAD_SELECT],
                irq_enable: CONTROL_RESET[BIT_IRQ_ENABLE],
                underflow_flag: CONTROL_RESET[BIT_UNDERFLOW],
                count_enable: CONTROL_RESET[BIT_COUNT_ENABLE],
                run: RUN_IDLE,
                toggle_level: 1'b0,
                reload_value_high: RELOAD_RESET[15:8],
                reload: RELOAD_RESET,
                low_capture: COUNT_RESET[7:0],
                wr_pending: 1'b0,
                wr_addr: 32'h0000_0000,
                rdata: 32'h0000_0000,
                ready: 1'b0,
                pin: 1'b0,
                pin_enable: 1'b0,
                irq: 1'b0
            };
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // write and read back to back with no idle may read stale control bits
    assign hrdata = state.rdata;
    assign hreadyout = state.ready;
    assign hresp = HRESP_OKAY;
    assign timer_output_pin = state.pin;
    assign timer_pin_output_enable = state.pin_enable;
    assign underflow_irq = state.irq;

endmodule // reload_down_timer_control

/* File: hdl/timer_pkg.sv */
// shared constants and types of the reload down-timer channel
// assumes one machine clock and an AHB-Lite master with 32-bit words
package timer_pkg;

    // ------------------------------------------------------------
    // register byte addresses, one aligned word each
    // ------------------------------------------------------------
    localparam logic [31:0] OFFSET_CONTROL = 32'h0000_0000;
    localparam logic [31:0] OFFSET_COUNT_HIGH = 32'h0000_0004;
    localparam logic [31:0] OFFSET_COUNT_LOW = 32'h0000_0008;
    localparam logic [31:0] OFFSET_COUNT_WORD = 32'h0000_000C;

    // ------------------------------------------------------------
    // control byte field positions
    // ------------------------------------------------------------
    localparam int BIT_RESERVED = 7;
    localparam int BIT_OUTPUT_ENABLE = 6;
    localparam int BIT_OUTPUT_LEVEL = 5;
    localparam int BIT_RELOAD_SELECT = 4;
    localparam int BIT_IRQ_ENABLE = 3;
    localparam int BIT_UNDERFLOW = 2;
    localparam int BIT_COUNT_ENABLE = 1;
    localparam int BIT_TRIGGER = 0;

    // ------------------------------------------------------------
    // values after reset and fixed values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // count clock is one event every this many hclk cycles
    localparam int COUNT_DIV_DEFAULT = 1;

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_ARMED = 2'b01,
        RUN_COUNTING = 2'b10
    } run_state_e;

endpackage

/* File: test/reload_down_timer_control_chk.sv */
// checker of the timer channel's bus answers, pin and request outputs
// assumes it is bound to the top module and sees only its ports
module reload_down_timer_control_chk
    import timer_pkg::*;
#(
    parameter int COUNT_DIV = COUNT_DIV_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hmastlock,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic gpio_port_value,
    input wire logic timer_output_pin,
    input wire logic timer_pin_output_enable,
    input wire logic underflow_irq
);
    // ------------------------------------------------------------
    // data phase tracking
    // ------------------------------------------------------------
    logic rd_phase;
    logic rd_lock;
    logic wr_ctrl;
    logic [31:0] rd_addr;
    logic [3:0] shadow;
    wire logic taken = hsel && hready && htrans == HTRANS_NONSEQ;
    // shadow keeps bits 6..3 of the control byte; word writes only land
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_phase <= 1'b0;
            rd_lock <= 1'b0;
            wr_ctrl <= 1'b0;
            rd_addr <= 32'h0;
            shadow <= 4'h0;
        end else begin
            rd_phase <= taken && !hwrite;
            rd_lock <= hmastlock;
            rd_addr <= haddr;
            wr_ctrl <= taken && hwrite && haddr == OFFSET_CONTROL && hsize == 3'h2;
            if (wr_ctrl) begin
                shadow <= hwdata[6:3];
            end
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_port_when_off: assert property ($past(hresetn) && !timer_pin_output_enable
        |-> timer_output_pin == $past(gpio_port_value)) else $error("pin not showing port value");
    a_oe_from_bit: assert property (timer_pin_output_enable == shadow[3])
        else $error("output enable differs from control bit");
    a_irq_gated: assert property (underflow_irq |-> shadow[0])
        else $error("request raised while disabled");
    a_ready_zero_wait: assert property ($past(hresetn) |-> hreadyout)
        else $error("wait state inserted");
    a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("response not okay");
    a_bit7_zero: assert property (rd_phase && rd_addr == OFFSET_CONTROL |-> hrdata[31:7] == 25'h0)
        else $error("control read shows upper bits");
    a_rmw_flag_one: assert property (rd_phase && rd_lock && rd_addr == OFFSET_CONTROL |-> hrdata[2])
        else $error("locked read shows flag clear");
    a_unmapped_zero: assert property (rd_phase && (rd_addr[31:4] != 28'h0 || rd_addr[1:0] != 2'h0)
        |-> hrdata == 32'h0) else $error("unmapped read not zero");
    a_ctrl_readback: assert property (rd_phase && rd_addr == OFFSET_CONTROL
        |-> hrdata[6:3] == $past(shadow)) else $error("control bits read back wrong");
endmodule // reload_down_timer_control_chk

bind reload_down_timer_control reload_down_timer_control_chk #(.COUNT_DIV(COUNT_DIV)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hmastlock(hmastlock), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gpio_port_value(gpio_port_value),
    .timer_output_pin(timer_output_pin), .timer_pin_output_enable(timer_pin_output_enable),
    .underflow_irq(underflow_irq)
);

/* File: test/reload_down_timer_control_tb.sv */
// self-checking bench of the timer channel over AHB-Lite
// assumes count divider 1, so one count event per hclk
module reload_down_timer_control_tb
    import timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic hmastlock = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic gpio_port_value = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic timer_output_pin;
    logic timer_pin_output_enable;
    logic underflow_irq;
    logic [31:0] v1;
    logic [31:0] v2;
    logic [31:0] lv;
    logic pv;
    int tg;
    int failures = 0;
    int compares = 0;

    always #50 hclk = ~hclk;

    reload_down_timer_control #(.COUNT_DIV(1)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hmastlock(hmastlock), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gpio_port_value(gpio_port_value),
        .timer_output_pin(timer_output_pin), .timer_pin_output_enable(timer_pin_output_enable),
        .underflow_irq(underflow_irq)
    );

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded, so a dead slave ends the run instead of hanging it
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            conclude();
        end
    endtask

    task automatic xfer(input logic wr, input logic lock, input logic [2:0] sz, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        hmastlock <= lock;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        htrans <= HTRANS_IDLE;
        hmastlock <= 1'b0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, 1'b0, 3'h2, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        xfer(1'b0, 1'b0, 3'h2, a, 32'h0, q);
    endtask

    task automatic rdc(input logic lock, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, lock, 3'h2, a, 32'h0, q);
        check(q, e);
    endtask

    // looks between edges, so the pin has settled
    task automatic pin_is(input logic e);
        @(negedge hclk);
        check({31'h0, timer_output_pin}, {31'h0, e});
        @(posedge hclk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(1'b0, OFFSET_CONTROL, 32'h0);
        rdc(1'b0, OFFSET_COUNT_WORD, 32'h0);
        rdc(1'b0, 32'h0000_0010, 32'h0);
        wr(OFFSET_CONTROL, 32'hFC);
        rdc(1'b0, OFFSET_CONTROL, 32'h78);
        check({31'h0, timer_pin_output_enable}, 32'h1);
        xfer(1'b1, 1'b0, 3'h0, OFFSET_CONTROL, 32'h0, v1);
        rdc(1'b0, OFFSET_CONTROL, 32'h78);
        wr(OFFSET_CONTROL, 32'h0);
        gpio_port_value <= 1'b1;
        @(posedge hclk);
        pin_is(1'b1);
        wr(OFFSET_COUNT_HIGH, 32'h12);
        wr(OFFSET_COUNT_LOW, 32'h34);
        wr(OFFSET_CONTROL, 32'h03);
        rd(OFFSET_COUNT_WORD, v1);
        check({24'h0, v1[15:8]}, 32'h12);
        v1 = v1 - 32'd2;
        rdc(1'b0, OFFSET_COUNT_HIGH, {24'h0, v1[15:8]});
        rdc(1'b0, OFFSET_COUNT_LOW, {24'h0, v1[7:0]});
        rdc(1'b0, OFFSET_CONTROL, 32'h02);
        rd(OFFSET_COUNT_WORD, v1);
        wr(OFFSET_COUNT_WORD, 32'h5);
        rd(OFFSET_COUNT_WORD, v2);
        check(v2, v1 - 32'd4);
        wr(OFFSET_CONTROL, 32'h0);
        rd(OFFSET_COUNT_WORD, v1);
        rdc(1'b0, OFFSET_COUNT_WORD, v1);
        // a high byte alone must stay pending, so the one-shot below still runs from 5
        wr(OFFSET_COUNT_HIGH, 32'h7F);
        for (int lvl = 0; lvl < 2; lvl++) begin
            lv = 32'(lvl) << 5;
            wr(OFFSET_CONTROL, 32'h43 | lv);
            repeat (2) @(posedge hclk);
            pin_is(!lv[5]);
            repeat (12) @(posedge hclk);
            pin_is(lv[5]);
            rdc(1'b0, OFFSET_COUNT_WORD, 32'hFFFF);
            rdc(1'b0, OFFSET_CONTROL, 32'h46 | lv);
            check({31'h0, underflow_irq}, 32'h0);
            wr(OFFSET_CONTROL, 32'h4E | lv);
            @(posedge hclk);
            check({31'h0, underflow_irq}, 32'h1);
            wr(OFFSET_CONTROL, 32'h4A | lv);
            @(posedge hclk);
            check({31'h0, underflow_irq}, 32'h0);
            rdc(1'b1, OFFSET_CONTROL, 32'h4E | lv);
            rdc(1'b0, OFFSET_CONTROL, 32'h4A | lv);
            wr(OFFSET_COUNT_WORD, 32'h3);
            wr(OFFSET_CONTROL, 32'h53 | lv);
            // read straight after the start lands while the channel still waits for its tick
            rdc(1'b0, OFFSET_CONTROL, 32'h53 | lv);
            pin_is(lv[5]);
            pv = lv[5];
            tg = 0;
            repeat (16) begin
                @(negedge hclk);
                if (timer_output_pin !== pv) begin
                    tg++;
                end
                pv = timer_output_pin;
            end
            @(posedge hclk);
            check(32'(tg), 32'd4);
            rd(OFFSET_COUNT_WORD, v1);
            check({31'h0, v1 <= 32'd3}, 32'h1);
            wr(OFFSET_CONTROL, 32'h01);
            rd(OFFSET_COUNT_WORD, v1);
            rdc(1'b0, OFFSET_COUNT_WORD, v1);
            rdc(1'b0, OFFSET_CONTROL, 32'h0);
            wr(OFFSET_CONTROL, 32'h02);
            rd(OFFSET_COUNT_WORD, v1);
            rdc(1'b0, OFFSET_COUNT_WORD, v1);
            wr(OFFSET_COUNT_WORD, 32'h5);
        end
        conclude();
    end
endmodule // reload_down_timer_control_tb
